// *** include/sdcfg_pkg.sv ***
// constants shared by the step/direction drive front end and its controller end
// assumes one 100 MHz clock and an active-low asynchronous reset on both ends
`default_nettype none

package sdcfg_pkg;

	// ****************************************
	// clock and times
	// ****************************************
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned TUNE_WIN_MS     = 1000;
	localparam int unsigned TUNE_RUN_MS     = 3000;
	localparam int unsigned RAMP_MS         = 250;
	localparam int unsigned ENABLE_WAIT_MS  = 5;
	localparam int unsigned DIR_SETUP_US    = 5;
	localparam int unsigned GREEN_FLASH_MS  = 250;
	localparam int unsigned RED_FLASH_MS    = 200;
	localparam int unsigned RED_PAUSE_MS    = 1500;
	localparam int unsigned STEP_IDLE_MS    = 10;   // quiet step input this long means standstill
	localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
	localparam int unsigned TUNE_WIN_CYC    = TUNE_WIN_MS * CYC_PER_MS;
	localparam int unsigned TUNE_RUN_CYC    = TUNE_RUN_MS * CYC_PER_MS;
	localparam int unsigned RAMP_CYC        = RAMP_MS * CYC_PER_MS;
	localparam int unsigned ENABLE_WAIT_CYC = ENABLE_WAIT_MS * CYC_PER_MS;
	localparam int unsigned DIR_SETUP_CYC   = (DIR_SETUP_US * CLK_HZ + 999_999) / 1_000_000;
	localparam int unsigned GREEN_FLASH_CYC = GREEN_FLASH_MS * CYC_PER_MS;
	localparam int unsigned RED_FLASH_CYC   = RED_FLASH_MS * CYC_PER_MS;
	localparam int unsigned RED_PAUSE_CYC   = RED_PAUSE_MS * CYC_PER_MS;
	localparam int unsigned STEP_IDLE_CYC   = STEP_IDLE_MS * CYC_PER_MS;

	// ****************************************
	// decode tables, index is the inverted switch code (on = 1)
	// ****************************************
	localparam int unsigned MICROSTEP_MIN   = 200;
	localparam int unsigned MICROSTEP_JOG   = 25600;
	localparam int unsigned RPM_MAX         = 500;
	localparam logic [8:0]  RPM_TABLE [8]   = '{9'h032, 9'h064, 9'h096, 9'h0c8,
		9'h0fa, 9'h12c, 9'h190, 9'h1f4};
	// peak current in tenths of an ampere
	localparam logic [6:0]  CURRENT_TABLE [8] = '{7'h1e, 7'h2a, 7'h30, 7'h38,
		7'h41, 7'h48, 7'h54, 7'h62};
	localparam int unsigned HOLD_LOW_PCT    = 50;
	localparam int unsigned HOLD_HIGH_PCT   = 90;

	// ****************************************
	// fault codes, value is burst length
	// ****************************************
	typedef enum logic [2:0] {
		SDCFG_FAULT_NONE   = 3'h0,
		SDCFG_FAULT_OVERI  = 3'h1,
		SDCFG_FAULT_OVERV  = 3'h2,
		SDCFG_FAULT_OVERT  = 3'h3,
		SDCFG_FAULT_WIND   = 3'h4,
		SDCFG_FAULT_INTERN = 3'h5
	} sdcfg_fault_t;

endpackage : sdcfg_pkg

`default_nettype wire

// *** include/sdcfg_link_if.sv ***
// wires between the controller and the drive: enable, step, direction
// assumes both ends share clock_in
`default_nettype none

interface sdcfg_link_if;
	logic enable;
	logic step;
	logic dir;

	modport drive (input enable, input step, input dir);
	modport ctrl  (output enable, output step, output dir);
endinterface : sdcfg_link_if

`default_nettype wire

// *** hdl/sdcfg_drive.sv ***
// drive end: switch decode, autotune start, step/direction and constant-speed
// motion, status indicators; analog current regulation lies outside
// assumes link inputs are synchronous to clock_in
`default_nettype none

module sdcfg_drive
	import sdcfg_pkg::*;
#(
	parameter int unsigned TUNE_WIN_CYCLES    = TUNE_WIN_CYC,
	parameter int unsigned TUNE_RUN_CYCLES    = TUNE_RUN_CYC,
	parameter int unsigned RAMP_CYCLES        = RAMP_CYC,
	parameter int unsigned GREEN_FLASH_CYCLES = GREEN_FLASH_CYC,
	parameter int unsigned RED_FLASH_CYCLES   = RED_FLASH_CYC,
	parameter int unsigned RED_PAUSE_CYCLES   = RED_PAUSE_CYC,
	parameter int unsigned STEP_IDLE_CYCLES   = STEP_IDLE_CYC
)(
	input  wire logic         clock_in,
	input  wire logic         rst_n_in,
	sdcfg_link_if.drive       link,
	input  wire logic [2:0]   run_current_sel_in,      // bit0..2, 1 = switch on
	input  wire logic [2:0]   resolution_speed_sel_in, // bit0..2, 1 = switch on
	input  wire logic         hold_current_tune_switch_in,
	input  wire logic         drive_mode_switch_in,
	input  wire logic [2:0]   fault_code_in,           // sdcfg_fault_t
	output logic [6:0]        current_out,             // tenths of an ampere
	output logic [14:0]       microsteps_out,
	output logic [8:0]        target_rpm_out,
	output logic [8:0]        speed_rpm_out,            // ramped speed
	output logic              step_mode_out,
	output logic              energised_out,
	output logic              tuning_out,
	output logic              microstep_pulse_out,
	output logic              move_dir_ccw_out,
	output logic              green_led_out,
	output logic              red_led_out
);

	// ****************************************
	// switch decode
	// ****************************************
	logic [2:0] run_idx;
	logic [2:0] res_idx;
	logic [6:0] run_current;
	logic       motion_cmd;
	logic       tuning;
	logic [8:0] speed;
	// inverted switch code: all on gives index 0
	assign run_idx = ~run_current_sel_in;
	assign res_idx = ~resolution_speed_sel_in;
	assign run_current = CURRENT_TABLE[run_idx];

	// registered outputs of the decode
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			current_out    <= 7'h00;
			microsteps_out <= 15'h0000;
			target_rpm_out <= 9'h000;
			step_mode_out  <= 1'b0;
		end
		else
		begin
			step_mode_out <= drive_mode_switch_in;
			if (drive_mode_switch_in)
				microsteps_out <= 15'(MICROSTEP_MIN << res_idx);
			else
				microsteps_out <= 15'(MICROSTEP_JOG);
			target_rpm_out <= RPM_TABLE[res_idx];
			if (link.enable && !motion_cmd)
				current_out <= hold_current_tune_switch_in
					? 7'((run_current * HOLD_LOW_PCT) / 100)
					: 7'((run_current * HOLD_HIGH_PCT) / 100);
			else
				current_out <= link.enable ? run_current : 7'h00;
		end
	end

	// ****************************************
	// autotune start detection
	// ****************************************
	typedef enum {TN_IDLE, TN_ON, TN_RUN} sdcfg_tune_t;
	sdcfg_tune_t tune_state;
	logic [31:0] tune_cnt;
	logic [31:0] off_cnt;
	assign tuning = (tune_state == TN_RUN);

	// off time of the tune switch, saturating
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			off_cnt <= 32'h0;
		else if (hold_current_tune_switch_in)
			off_cnt <= 32'h0;
		else if (off_cnt < TUNE_WIN_CYCLES)
			off_cnt <= off_cnt + 32'h1;
	end

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			tune_state <= TN_IDLE;
			tune_cnt   <= 32'h0;
		end
		else
		begin
			tune_cnt <= tune_cnt + 32'h1;
			unique case (tune_state)
				TN_IDLE:
					if (hold_current_tune_switch_in && off_cnt >= TUNE_WIN_CYCLES)
					begin
						tune_state <= TN_ON;
						tune_cnt   <= 32'h0;
					end
				TN_ON:
					if (tune_cnt >= TUNE_WIN_CYCLES - 1)
						tune_state <= TN_IDLE;
					else if (!hold_current_tune_switch_in)
					begin
						tune_state <= TN_RUN;
						tune_cnt   <= 32'h0;
					end
				TN_RUN:
					if (tune_cnt >= TUNE_RUN_CYCLES - 1)
						tune_state <= TN_IDLE;
			endcase
		end
	end
	assign tuning_out = tuning;

	// ****************************************
	// step/direction mode
	// ****************************************
	logic step_q;
	logic ramp_active;
	logic sd_pulse;
	logic jog_pulse;
	logic [31:0] idle_cnt;
	assign sd_pulse = drive_mode_switch_in && link.enable && !tuning
		&& step_q && !link.step;

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			step_q <= 1'b0;
		else
			step_q <= link.step;
	end
	// cycles since the last step level change, saturating
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			idle_cnt <= 32'hffff_ffff;
		else if (step_q != link.step)
			idle_cnt <= 32'h0;
		else if (idle_cnt < STEP_IDLE_CYCLES)
			idle_cnt <= idle_cnt + 32'h1;
	end

	// ****************************************
	// constant-speed mode with ramp
	// ****************************************
	logic [31:0] ramp_cnt;
	logic [63:0] phase;
	logic [63:0] phase_sum;
	logic        jog_cw;
	logic        jog_ccw;
	assign jog_cw  = link.step && !link.dir;
	assign jog_ccw = !link.step && link.dir;
	assign motion_cmd = link.enable && !tuning && (drive_mode_switch_in
		? (step_q != link.step || idle_cnt < STEP_IDLE_CYCLES) : (jog_cw || jog_ccw));
	assign ramp_active = !drive_mode_switch_in && link.enable && !tuning
		&& (jog_cw || jog_ccw);
	assign speed = 9'((64'(target_rpm_out) * ramp_cnt) / RAMP_CYCLES);

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			ramp_cnt <= 32'h0;
		else if (ramp_active && ramp_cnt < RAMP_CYCLES)
			ramp_cnt <= ramp_cnt + 32'h1;
		else if (!ramp_active && ramp_cnt != 32'h0)
			ramp_cnt <= ramp_cnt - 32'h1;
	end

	// microstep rate accumulator: rpm * 25600 steps per minute of clock cycles
	assign phase_sum = phase + 64'(speed) * 64'(MICROSTEP_JOG);
	assign jog_pulse = !drive_mode_switch_in && phase_sum >= 64'(CLK_HZ) * 64'd60;
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			phase <= 64'h0;
		else if (drive_mode_switch_in)
			phase <= 64'h0;
		else if (jog_pulse)
			phase <= phase_sum - 64'(CLK_HZ) * 64'd60;
		else
			phase <= phase_sum;
	end

	// motion outputs and direction latch
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			microstep_pulse_out <= 1'b0;
			move_dir_ccw_out    <= 1'b0;
			speed_rpm_out       <= 9'h000;
		end
		else
		begin
			microstep_pulse_out <= sd_pulse || jog_pulse;
			speed_rpm_out       <= speed;
			if (sd_pulse)
				move_dir_ccw_out <= link.dir;
			else if (ramp_active)
				move_dir_ccw_out <= jog_ccw;
		end
	end

	// ****************************************
	// status indicators
	// ****************************************
	logic [31:0] green_cnt;
	logic        green_blink;
	logic [31:0] red_cnt;
	logic [3:0]  red_phase;

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			green_cnt   <= 32'h0;
			green_blink <= 1'b0;
		end
		else if (green_cnt >= GREEN_FLASH_CYCLES - 1)
		begin
			green_cnt   <= 32'h0;
			green_blink <= !green_blink;
		end
		else
			green_cnt <= green_cnt + 32'h1;
	end

	// red burst sequencer, even phases lit except the closing pause phase
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			red_cnt   <= 32'h0;
			red_phase <= 4'h0;
		end
		else if (fault_code_in == SDCFG_FAULT_NONE || fault_code_in > SDCFG_FAULT_INTERN)
		begin
			red_cnt   <= 32'h0;
			red_phase <= 4'h0;
		end
		else if (red_phase == {fault_code_in, 1'b0})
		begin
			if (red_cnt >= RED_PAUSE_CYCLES - 1)
			begin
				red_cnt   <= 32'h0;
				red_phase <= 4'h0;
			end
			else
				red_cnt <= red_cnt + 32'h1;
		end
		else if (red_cnt >= RED_FLASH_CYCLES - 1)
		begin
			red_cnt   <= 32'h0;
			red_phase <= red_phase + 4'h1;
		end
		else
			red_cnt <= red_cnt + 32'h1;
	end

	// indicator outputs
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			green_led_out <= 1'b0;
			red_led_out   <= 1'b0;
			energised_out <= 1'b0;
		end
		else
		begin
			energised_out <= link.enable;
			if (tuning)
				green_led_out <= 1'b0;
			else
				green_led_out <= link.enable ? 1'b1 : green_blink;
			red_led_out <= fault_code_in != SDCFG_FAULT_NONE
				&& fault_code_in <= SDCFG_FAULT_INTERN
				&& red_phase != {fault_code_in, 1'b0} && !red_phase[0];
		end
	end

endmodule : sdcfg_drive

`default_nettype wire

// *** hdl/sdcfg_ctrl.sv ***
// controller end: drives enable, step and direction to the drive, honouring
// the enable delay and the direction setup before pulses resume
// assumes the user-side requests are synchronous to clock_in
`default_nettype none

module sdcfg_ctrl
	import sdcfg_pkg::*;
#(
	parameter int unsigned ENABLE_WAIT_CYCLES = ENABLE_WAIT_CYC,
	parameter int unsigned DIR_SETUP_CYCLES   = DIR_SETUP_CYC,
	parameter int unsigned HALF_PERIOD_CYCLES = 50
)(
	input  wire logic   clock_in,
	input  wire logic   rst_n_in,
	sdcfg_link_if.ctrl  link,
	input  wire logic   enable_req_in,
	input  wire logic   jog_mode_in,   // 1 = drive in constant-speed mode
	input  wire logic   move_req_in,   // step pulses or the jog level of dir_q while high; step low otherwise, which with dir_q at 1 is the ccw jog level
	input  wire logic   ccw_in,
	output logic        ready_out      // enable delay and setup satisfied
);

	// ****************************************
	// enable delay and direction setup
	// ****************************************
	logic [31:0] wait_cnt;
	logic [31:0] setup_cnt;
	logic [31:0] half_cnt;
	logic        dir_q;
	logic        step_q;
	logic        en_ok;
	logic        dir_ok;
	assign en_ok  = link.enable && wait_cnt >= ENABLE_WAIT_CYCLES;
	assign dir_ok = setup_cnt >= DIR_SETUP_CYCLES;
	assign ready_out = en_ok && dir_ok;

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			wait_cnt <= 32'h0;
		else if (!enable_req_in)
			wait_cnt <= 32'h0;
		else if (wait_cnt < ENABLE_WAIT_CYCLES)
			wait_cnt <= wait_cnt + 32'h1;
	end

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			dir_q     <= 1'b0;
			setup_cnt <= 32'h0;
		end
		// direction held until enable wait is over
		else if (ccw_in != dir_q && !step_q && en_ok)
		begin
			dir_q     <= ccw_in;
			setup_cnt <= 32'h0;
		end
		else if (setup_cnt < DIR_SETUP_CYCLES)
			setup_cnt <= setup_cnt + 32'h1;
	end

	// step generator or jog level
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			step_q   <= 1'b0;
			half_cnt <= 32'h0;
		end
		else if (!(move_req_in && ready_out && ccw_in == dir_q))
		begin
			step_q   <= 1'b0;
			half_cnt <= 32'h0;
		end
		else if (jog_mode_in)
			step_q <= !dir_q;
		else if (half_cnt >= HALF_PERIOD_CYCLES - 1)
		begin
			half_cnt <= 32'h0;
			step_q   <= !step_q;
		end
		else
			half_cnt <= half_cnt + 32'h1;
	end

	assign link.enable = enable_req_in;
	assign link.step   = step_q;
	assign link.dir    = dir_q;

endmodule : sdcfg_ctrl

`default_nettype wire

// *** dv/sdcfg_properties.sv ***
// checker of the enable, step and direction wires between the two ends
// assumes it sits beside the link interface, on the one clock
`default_nettype none

module sdcfg_properties #(
	parameter int unsigned ENABLE_WAIT_CYCLES = 20
)(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic enable,
	input wire logic step,
	input wire logic dir
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] en_cnt;

	// ****************
	// cycles since enable rose, saturating
	// ****************
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			en_cnt <= 8'h00;
		else if (!enable)
			en_cnt <= 8'h00;
		else if (en_cnt != 8'hff)
			en_cnt <= en_cnt + 8'h01;
	end

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);

	property p_step_wait;
		$rose(step) |-> {24'h000000, en_cnt} >= ENABLE_WAIT_CYCLES;
	endproperty
	a_step_wait: assert property (p_step_wait)
		else $error("step rose too soon after enable");

	property p_step_enable;
		step |-> enable;
	endproperty
	a_step_enable: assert property (p_step_enable)
		else $error("step high without enable");

	property p_dir_wait;
		$rose(dir) |-> enable && ({24'h000000, en_cnt} >= ENABLE_WAIT_CYCLES);
	endproperty
	a_dir_wait: assert property (p_dir_wait)
		else $error("direction raised too soon after enable");

	property p_dir_setup;
		$changed(dir) && $stable(step) |-> !step [*5];
	endproperty
	a_dir_setup: assert property (p_dir_setup)
		else $error("step resumed inside direction setup");

	// direction moves only with step low
	property p_dir_step_low;
		$changed(dir) |-> !step && !$past(step);
	endproperty
	a_dir_step_low: assert property (p_dir_step_low)
		else $error("direction changed while step was high");

	property p_enable_quiet;
		$rose(enable) |-> !step;
	endproperty
	a_enable_quiet: assert property (p_enable_quiet)
		else $error("step high as enable rose");
endmodule // sdcfg_properties

`default_nettype wire

// *** dv/step_dir_drive_config_logic_bench.sv ***
// bench: controller end feeding the drive end, plus a bench-driven link
// assumes the shortened counts set below on both design ends
`default_nettype none

`define CK(nm, ex, gt) \
	begin \
		checked++; \
		if ((gt) !== (ex)) \
		begin \
			fail_count++; \
			$display("Error %s expected %0h seen %0h", nm, ex, gt); \
		end \
	end

module step_dir_drive_config_logic_bench
	import sdcfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// shortened counts shared by both ends and the checker
	localparam int unsigned EN_WAIT   = 20;
	localparam int unsigned DIR_SETUP = 5;
	localparam int unsigned HALF_PER  = 4;
	localparam int unsigned TUNE_WIN  = 100;
	localparam int unsigned TUNE_RUN  = 300;
	localparam int unsigned RAMP      = 50;
	localparam int unsigned GREEN_FL  = 4;
	localparam int unsigned RED_FL    = 4;
	localparam int unsigned RED_PAUSE = 20;
	localparam int unsigned STEP_IDLE = 10;

	logic clock_in, rst_n_in, enable_req, jog_mode, move_req, ccw, ready;
	logic [2:0] sw_cur, sw_res, fault;
	logic sw_hold, sw_mode, smode, energ, tuning, pulse, ccw_o, green, red;
	logic pulse_b, ccw_b;
	logic [6:0] current;
	logic [14:0] usteps;
	logic [8:0] trpm, srpm, srpm_b;
	int fail_count, checked;

	sdcfg_link_if link_a();
	sdcfg_link_if link_b();
	assign jog_mode = ~sw_mode;

	sdcfg_ctrl #(.ENABLE_WAIT_CYCLES(EN_WAIT), .DIR_SETUP_CYCLES(DIR_SETUP),
		.HALF_PERIOD_CYCLES(HALF_PER))
	sdcfg_ctrl_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(link_a),
		.enable_req_in(enable_req), .jog_mode_in(jog_mode), .move_req_in(move_req),
		.ccw_in(ccw), .ready_out(ready));

	sdcfg_drive #(.TUNE_WIN_CYCLES(TUNE_WIN), .TUNE_RUN_CYCLES(TUNE_RUN), .RAMP_CYCLES(RAMP),
		.GREEN_FLASH_CYCLES(GREEN_FL), .RED_FLASH_CYCLES(RED_FL),
		.RED_PAUSE_CYCLES(RED_PAUSE), .STEP_IDLE_CYCLES(STEP_IDLE))
	sdcfg_drive_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(link_a),
		.run_current_sel_in(sw_cur), .resolution_speed_sel_in(sw_res),
		.hold_current_tune_switch_in(sw_hold), .drive_mode_switch_in(sw_mode),
		.fault_code_in(fault), .current_out(current), .microsteps_out(usteps),
		.target_rpm_out(trpm), .speed_rpm_out(srpm), .step_mode_out(smode),
		.energised_out(energ), .tuning_out(tuning), .microstep_pulse_out(pulse),
		.move_dir_ccw_out(ccw_o), .green_led_out(green), .red_led_out(red));

	// second drive on a link driven by the bench itself
	sdcfg_drive #(.TUNE_WIN_CYCLES(TUNE_WIN), .TUNE_RUN_CYCLES(TUNE_RUN), .RAMP_CYCLES(RAMP),
		.GREEN_FLASH_CYCLES(GREEN_FL), .RED_FLASH_CYCLES(RED_FL),
		.RED_PAUSE_CYCLES(RED_PAUSE), .STEP_IDLE_CYCLES(STEP_IDLE))
	sdcfg_drive_b_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .link(link_b),
		.run_current_sel_in(sw_cur), .resolution_speed_sel_in(sw_res),
		.hold_current_tune_switch_in(sw_hold), .drive_mode_switch_in(sw_mode),
		.fault_code_in(fault), .current_out(), .microsteps_out(), .target_rpm_out(),
		.speed_rpm_out(srpm_b), .step_mode_out(), .energised_out(), .tuning_out(),
		.microstep_pulse_out(pulse_b), .move_dir_ccw_out(ccw_b), .green_led_out(),
		.red_led_out());

	sdcfg_properties #(.ENABLE_WAIT_CYCLES(EN_WAIT)) sdcfg_properties_i (.clock_in(clock_in),
		.rst_n_in(rst_n_in), .enable(link_a.enable), .step(link_a.step), .dir(link_a.dir));

	task cyc(input int n);
		repeat (n) @(negedge clock_in);
	endtask

	task print_verdict;
		$display("checked %0d failed %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one falling step edge on the bench link, pulse checked in its cycle
	task step_b(input logic ex);
		link_b.step = 1'b1;
		cyc(1);
		link_b.step = 1'b0;
		cyc(1);
		`CK("step pulse", ex, pulse_b)
		cyc(1);
		`CK("pulse width", 1'b0, pulse_b)
	endtask

	task t_decode;
		for (int i = 0; i < 8; i++)
		begin
			sw_cur = ~3'(i);
			sw_res = ~3'(i);
			sw_mode = 1'b1;
			cyc(3);
			`CK("microsteps", 15'(MICROSTEP_MIN << i), usteps)
			`CK("step mode", 1'b1, smode)
			`CK("hold low", 7'(CURRENT_TABLE[i] * HOLD_LOW_PCT / 100), current)
			sw_mode = 1'b0;
			cyc(3);
			`CK("rpm", RPM_TABLE[i], trpm)
			`CK("jog microsteps", 15'(MICROSTEP_JOG), usteps)
		end
		$display("t_decode done");
	endtask

	task t_pulse;
		int n;
		int p;
		logic ls;
		n = 0;
		p = 0;
		ls = 1'b0;
		sw_mode = 1'b1;
		sw_cur = 3'h0;
		`CK("ready", 1'b1, ready)
		move_req = 1'b1;
		for (int i = 0; i < 400; i++)
		begin
			ccw = (i >= 200);
			cyc(1);
			n += (ls && !link_a.step);
			ls = link_a.step;
			p += pulse;
			if (i == 190)
				`CK("run current", CURRENT_TABLE[7], current)
		end
		`CK("ccw", 1'b1, ccw_o)
		move_req = 1'b0;
		repeat (20)
		begin
			cyc(1);
			n += (ls && !link_a.step);
			ls = link_a.step;
			p += pulse;
		end
		`CK("pulses", n, p)
		`CK("pulses seen", 1'b1, n > 20)
		`CK("standstill", 7'(CURRENT_TABLE[7] * HOLD_LOW_PCT / 100), current)
		$display("t_pulse done");
	endtask

	task t_refuse;
		repeat (3) step_b(1'b0);
		link_b.enable = 1'b1;
		link_b.dir = 1'b1;
		cyc(25);
		repeat (3) step_b(1'b1);
		`CK("ccw b", 1'b1, ccw_b)
		$display("t_refuse done");
	endtask

	task t_jog;
		int p;
		p = 0;
		sw_mode = 1'b0;
		sw_res = 3'h7;
		ccw = 1'b0;
		move_req = 1'b1;
		while (srpm == 9'h000 && p < 100)
		begin
			cyc(1);
			p++;
		end
		cyc(20);
		`CK("ramping", 1'b1, srpm > 9'h000 && srpm < 9'h032)
		cyc(40);
		`CK("speed", 9'h032, srpm)
		`CK("cw", 1'b0, ccw_o)
		p = 0;
		repeat (10000)
		begin
			cyc(1);
			p += pulse;
		end
		`CK("jog pulses", 1'b1, p >= 2 && p <= 3)
		move_req = 1'b0;
		cyc(60);
		`CK("stopped", 9'h000, srpm)
		link_b.step = 1'b1;
		cyc(60);
		`CK("both high", 9'h000, srpm_b)
		link_b.step = 1'b0;
		cyc(60);
		`CK("ccw speed", 9'h032, srpm_b)
		`CK("ccw dir", 1'b1, ccw_b)
		link_b.dir = 1'b0;
		cyc(60);
		`CK("both low", 9'h000, srpm_b)
		$display("t_jog done");
	endtask

	task t_tune;
		sw_mode = 1'b1;
		sw_hold = 1'b0;
		cyc(3);
		`CK("long on", 1'b0, tuning)
		`CK("hold high", 7'(CURRENT_TABLE[7] * HOLD_HIGH_PCT / 100), current)
		sw_hold = 1'b1;
		cyc(5);
		sw_hold = 1'b0;
		cyc(3);
		`CK("short off", 1'b0, tuning)
		cyc(110);
		sw_hold = 1'b1;
		cyc(5);
		sw_hold = 1'b0;
		cyc(3);
		`CK("tuning", 1'b1, tuning)
		`CK("green dark", 1'b0, green)
		step_b(1'b0);
		cyc(300);
		`CK("tune over", 1'b0, tuning)
		`CK("green back", 1'b1, green)
		$display("t_tune done");
	endtask

	task t_leds;
		int t;
		int r;
		logic lr;
		enable_req = 1'b0;
		cyc(5);
		`CK("energised", 1'b0, energ)
		`CK("not ready", 1'b0, ready)
		t = 0;
		lr = green;
		repeat (40)
		begin
			cyc(1);
			t += (green != lr);
			lr = green;
		end
		`CK("flashing", 1'b1, t >= 9 && t <= 11)
		for (int f = 1; f < 6; f++)
		begin
			fault = 3'(f);
			t = 0;
			while (!red && t < 100)
			begin
				cyc(1);
				t++;
			end
			r = 0;
			t = 0;
			lr = 1'b0;
			while (t < 10)
			begin
				r += (red && !lr);
				t = red ? 0 : t + 1;
				lr = red;
				cyc(1);
			end
			`CK("bursts", f, r)
			fault = 3'h0;
			cyc(40);
		end
		`CK("red off", 1'b0, red)
		$display("t_leds done");
	endtask

	initial
	begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end

	initial
	begin
		#600000;
		fail_count++;
		print_verdict;
	end

	initial
	begin
		fail_count = 0;
		checked = 0;
		rst_n_in = 1'b0;
		{enable_req, move_req, ccw, sw_mode, fault} = '0;
		{sw_cur, sw_res, sw_hold} = 7'h7f;
		{link_b.enable, link_b.step, link_b.dir} = 3'h0;
		cyc(5);
		rst_n_in = 1'b1;
		enable_req = 1'b1;
		cyc(25);
		t_decode;
		t_pulse;
		t_refuse;
		t_jog;
		t_tune;
		t_leds;
		print_verdict;
	end
endmodule // step_dir_drive_config_logic_bench

`default_nettype wire
